/* File: common/lamp_shutdown_cfg.svh */
`ifndef LAMP_SHUTDOWN_CFG_SVH
`define LAMP_SHUTDOWN_CFG_SVH

// ==========================================================================
// Command byte decoding.
// ==========================================================================
`define CMD_GROUP_LEGACY_BIT 7
`define CMD_GROUP_HI 7
`define CMD_GROUP_LO 6
`define CMD_GROUP_PACKED 2'h2
`define CMD_GROUP_IDENT 2'h3
`define CMD_SEL_BRIGHT 2'h1
`define CMD_SEL_MODE 2'h2
`define CMD_SEL_PART 2'h3
`define CMD_SEL_REVISION 2'h0

// ==========================================================================
// Field positions.
// ==========================================================================
`define FORCE_OFF_POS 2
`define PIN_HIGH_POS 1
`define PIN_LOW_POS 0
`define LAMP_FAULT_POS 1
`define OVERCURRENT_POS 0

// ==========================================================================
// Reset values and mode read padding.
// ==========================================================================
`define MODE_RESET 3'h1
`define STATUS_RESET 2'h3
`define MODE_PAD_ONES 3'h7

// ==========================================================================
// Timing.
// ==========================================================================
`define LAMP_OUT_TIME_MS 1000
`define CLOCK_FREQ_KHZ 100000

`endif

/* File: common/lamp_shutdown_pkg.sv */
package lamp_shutdown_pkg;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_PENDING = 1'b1
  } write_state_t;

endpackage

/* File: hw/lamp_out_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module lamp_out_timer #(
  parameter int unsigned TIMEOUT_CYCLES = 100000000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic run,
  output logic expired
);

  localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
    $error("lamp_out_timer: TIMEOUT_CYCLES must be at least 2");
  end

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire at_end = (count == CW'(TIMEOUT_CYCLES - 1));

  // The count restarts whenever the lamp is not driven or current is seen.
  assign next_count = (!run || at_end) ? '0 : count + CW'(1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
      expired <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      expired <= run && at_end; // [R1]
    end
  end

  property p_expire_after_full_run;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && run && at_end) |=> expired;
  endproperty
  a_expire_after_full_run: assert property (p_expire_after_full_run) // [R1]
    else $error("timer did not expire at end of count");

  property p_no_expire_without_run;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && !run) |=> !expired;
  endproperty
  a_no_expire_without_run: assert property (p_no_expire_without_run) // [R1]
    else $error("timer expired while not running");

endmodule

`default_nettype wire

/* File: hw/lamp_shutdown_status_regs.sv */
// Notes on behaviour
// R1: Clear lamp fault flag after 1 s driven with no lamp current seen.
// R2: Lamp fault flag stays cleared after the lamp-out condition goes away.
// R3: While lamp fault flag is zero, the lamp is forced off.
// R4: Each dimming period end, overcurrent flag becomes not-overcurrent-seen.
// R5: Force-off bit set turns lamp off and sets lamp fault flag.
// R6: Pin high with off-when-pin-high set forces lamp off, sets fault flag.
// R7: Pin low with off-when-pin-low set forces lamp off, sets fault flag.
// R8: Reset sets both status flags to one.
// R9: Status flags are read-only; writes to them are ignored.
// R10: Lamp fault flag is set only by reset or by forcing the lamp off.
// R11: Identification registers return fixed codes and ignore writes.
// R12: Command 0xA9 returns the status flags in reversed bit order.
// R13: Reset loads shutdown mode with 001.
// R14: Written values apply only after stop or repeated start.
// R15: Register access keeps working while the lamp is shut down.
// R16: Lamp runs only with no shutdown condition and lamp fault flag one.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_shutdown_cfg.svh"

module lamp_shutdown_status_regs #(
  parameter int unsigned LAMP_OUT_CYCLES = `LAMP_OUT_TIME_MS * `CLOCK_FREQ_KHZ,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER_CODE = 8'hA5,
  parameter logic [7:0] PART_CODE = 8'h3C,
  parameter logic [7:0] REVISION_CODE = 8'h01
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic suspend_pin,
  input wire logic lamp_current_sense,
  input wire logic overcurrent_event,
  input wire logic dimming_period_end,
  input wire logic [4:0] bright_code,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic bus_stop,
  input wire logic bus_abort,
  output logic [7:0] rd_data,
  output logic lamp_enable,
  output logic lamp_fault_flag,
  output logic overcurrent_flag,
  output logic [2:0] shutdown_mode_control
);

  // ========================================================================
  // Pin synchronisers.
  // ========================================================================
  wire [1:0] pin_sync;
  wire [1:0] pin_raw = {suspend_pin, lamp_current_sense};

  // Each bit keeps its own flops, so no vector is written by two processes.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic meta;
    logic sync;
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        meta <= 1'b0;
        sync <= 1'b0;
      end else if (clk_en) begin
        meta <= pin_raw[i];
        sync <= meta;
      end
    end
    assign pin_sync[i] = sync;
  end

  wire suspend_sync = pin_sync[1];
  wire sense_sync = pin_sync[0];

  // ========================================================================
  // Shutdown decision.
  // ========================================================================
  wire force_off_bit = shutdown_mode_control[`FORCE_OFF_POS];
  wire off_when_pin_high = shutdown_mode_control[`PIN_HIGH_POS];
  wire off_when_pin_low = shutdown_mode_control[`PIN_LOW_POS];
  wire shut_force = force_off_bit; // [R5]
  wire shut_high = suspend_sync && off_when_pin_high; // [R6]
  wire shut_low = !suspend_sync && off_when_pin_low; // [R7]
  wire shutdown = shut_force || shut_high || shut_low;
  wire next_lamp_enable = !shutdown && lamp_fault_flag; // [R3] [R16]

  // ========================================================================
  // Lamp-out timing and status flags.
  // ========================================================================
  logic lamp_out_expired;
  logic oc_seen;

  lamp_out_timer #(
    .TIMEOUT_CYCLES(LAMP_OUT_CYCLES)
  ) u_lamp_out_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run(lamp_enable && !sense_sync),
    .expired(lamp_out_expired)
  );

  // Forcing the lamp off wins over a lamp-out expiry in the same cycle.
  wire next_lamp_fault = shutdown ? 1'b1 : // [R10]
                         (lamp_out_expired ? 1'b0 : lamp_fault_flag); // [R1] [R2]
  wire oc_in_period = oc_seen || overcurrent_event;
  wire next_oc_flag = dimming_period_end ? !oc_in_period : overcurrent_flag; // [R4]
  wire next_oc_seen = dimming_period_end ? 1'b0 : oc_in_period;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lamp_fault_flag <= 1'(`STATUS_RESET >> `LAMP_FAULT_POS); // [R8]
      overcurrent_flag <= 1'b1; // [R8]
      oc_seen <= 1'b0;
      lamp_enable <= 1'b0;
    end else if (clk_en) begin
      lamp_fault_flag <= next_lamp_fault;
      overcurrent_flag <= next_oc_flag;
      oc_seen <= next_oc_seen;
      lamp_enable <= next_lamp_enable;
    end
  end

  // ========================================================================
  // Register writes, held until the transfer ends.
  // ========================================================================
  lamp_shutdown_pkg::write_state_t wr_state;
  lamp_shutdown_pkg::write_state_t next_wr_state;
  logic [7:0] pend_cmd;
  logic [7:0] pend_data;

  wire pend_is_mode = !pend_cmd[`CMD_GROUP_LEGACY_BIT] &&
                      (pend_cmd[1:0] == `CMD_SEL_MODE);
  // Only the mode field is stored; status bits and identity codes are dropped.
  wire apply_write = (wr_state == lamp_shutdown_pkg::WR_PENDING) && bus_stop; // [R14]
  wire mode_load = apply_write && pend_is_mode; // [R9] [R11]

  always_comb begin
    case (wr_state)
      lamp_shutdown_pkg::WR_IDLE: begin
        next_wr_state = wr_strobe ? lamp_shutdown_pkg::WR_PENDING
                                  : lamp_shutdown_pkg::WR_IDLE;
      end
      lamp_shutdown_pkg::WR_PENDING: begin
        next_wr_state = (bus_stop || bus_abort) ? lamp_shutdown_pkg::WR_IDLE
                                                : lamp_shutdown_pkg::WR_PENDING;
      end
      default: begin
        next_wr_state = lamp_shutdown_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_state <= lamp_shutdown_pkg::WR_IDLE;
      pend_cmd <= 8'h00;
      pend_data <= 8'h00;
      shutdown_mode_control <= `MODE_RESET; // [R13]
    end else if (clk_en) begin
      wr_state <= next_wr_state;
      if (wr_strobe) begin
        pend_cmd <= cmd_byte;
        pend_data <= wr_data;
      end
      if (mode_load) begin
        shutdown_mode_control <= pend_data[2:0]; // [R14]
      end
    end
  end

  // ========================================================================
  // Read data selection, independent of lamp state.
  // ========================================================================
  wire [1:0] cmd_group = cmd_byte[`CMD_GROUP_HI:`CMD_GROUP_LO];
  wire [1:0] status_fwd = {lamp_fault_flag, overcurrent_flag};
  wire [1:0] status_rev = {overcurrent_flag, lamp_fault_flag}; // [R12]
  wire [7:0] rd_bright = {3'h0, bright_code};
  wire [7:0] rd_mode = {status_fwd, `MODE_PAD_ONES, shutdown_mode_control};
  wire [7:0] rd_packed = {bright_code, 1'b0, cmd_byte[0] ? status_rev : status_fwd};
  wire [7:0] rd_ident = cmd_byte[0] ? PART_CODE : MAKER_CODE; // [R11]
  wire [7:0] rd_legacy = (cmd_byte[1:0] == `CMD_SEL_BRIGHT) ? rd_bright :
                         (cmd_byte[1:0] == `CMD_SEL_MODE) ? rd_mode :
                         (cmd_byte[1:0] == `CMD_SEL_PART) ? PART_CODE :
                         REVISION_CODE;
  wire [7:0] next_rd_data = !cmd_byte[`CMD_GROUP_LEGACY_BIT] ? rd_legacy :
                            (cmd_group == `CMD_GROUP_PACKED) ? rd_packed :
                            rd_ident; // [R15]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rd_data <= next_rd_data;
    end
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  sequence s_write_taken;
    clk_en && wr_strobe && (wr_state == lamp_shutdown_pkg::WR_IDLE);
  endsequence

  sequence s_quiet_then_stop;
    (clk_en && !bus_stop && !bus_abort) [*2] ##1 (clk_en && bus_stop);
  endsequence

  property p_reset_values;
    @(posedge clock) sys_rst |=>
      lamp_fault_flag && overcurrent_flag && (shutdown_mode_control == `MODE_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) // [R8] [R13]
    else $error("reset values wrong");

  property p_fault_forces_off;
    @(posedge clock) disable iff (sys_rst) (clk_en && !lamp_fault_flag) |=> !lamp_enable;
  endproperty
  a_fault_forces_off: assert property (p_fault_forces_off) // [R3]
    else $error("lamp driven while fault flag low");

  property p_force_off;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && force_off_bit) |=> (!lamp_enable && lamp_fault_flag);
  endproperty
  a_force_off: assert property (p_force_off) // [R5]
    else $error("force-off bit did not shut lamp");

  property p_pin_high_off;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && suspend_sync && off_when_pin_high) |=> (!lamp_enable && lamp_fault_flag);
  endproperty
  a_pin_high_off: assert property (p_pin_high_off) // [R6]
    else $error("pin-high shutdown failed");

  property p_pin_low_off;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && !suspend_sync && off_when_pin_low) |=> (!lamp_enable && lamp_fault_flag);
  endproperty
  a_pin_low_off: assert property (p_pin_low_off) // [R7]
    else $error("pin-low shutdown failed");

  property p_run_when_clear;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && !shutdown && lamp_fault_flag) |=> lamp_enable;
  endproperty
  a_run_when_clear: assert property (p_run_when_clear) // [R16]
    else $error("lamp not enabled with no shutdown");

  property p_fault_latched;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && !lamp_fault_flag && !shutdown) |=> !lamp_fault_flag;
  endproperty
  a_fault_latched: assert property (p_fault_latched) // [R2] [R10]
    else $error("fault flag set without shutdown");

  property p_lamp_out_clears;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && lamp_out_expired && !shutdown) |=> !lamp_fault_flag;
  endproperty
  a_lamp_out_clears: assert property (p_lamp_out_clears) // [R1]
    else $error("lamp-out expiry did not clear fault flag");

  property p_overcurrent_period;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && dimming_period_end) |=> (overcurrent_flag == !$past(oc_in_period));
  endproperty
  a_overcurrent_period: assert property (p_overcurrent_period) // [R4]
    else $error("overcurrent flag wrong at period end");

  property p_write_waits_for_stop;
    @(posedge clock) disable iff (sys_rst)
      (s_write_taken ##1 s_quiet_then_stop) |->
        ($past(shutdown_mode_control, 1) == $past(shutdown_mode_control, 3));
  endproperty
  a_write_waits_for_stop: assert property (p_write_waits_for_stop) // [R14]
    else $error("mode changed before stop");

  property p_mode_applied;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && mode_load) |=> (shutdown_mode_control == $past(pend_data[2:0]));
  endproperty
  a_mode_applied: assert property (p_mode_applied) // [R14]
    else $error("mode write not applied at stop");

  property p_reversed_status;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && (cmd_group == `CMD_GROUP_PACKED) && cmd_byte[0]) |=>
        (rd_data[1:0] == {$past(overcurrent_flag), $past(lamp_fault_flag)});
  endproperty
  a_reversed_status: assert property (p_reversed_status) // [R12]
    else $error("reversed status order wrong");

  property p_ident_fixed;
    @(posedge clock) disable iff (sys_rst)
      (clk_en && (cmd_group == `CMD_GROUP_IDENT) && !cmd_byte[0]) |=> (rd_data == MAKER_CODE);
  endproperty
  a_ident_fixed: assert property (p_ident_fixed) // [R11] [R15]
    else $error("maker code read wrong");

endmodule

`default_nettype wire

/* File: tb/smbus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Protocol engine side: command, data byte and end-of-transfer pulses.
// ==========================================================================
module smbus_host_model (
  input wire logic clock,
  output logic [7:0] cmd_byte,
  output logic wr_strobe,
  output logic [7:0] wr_data,
  output logic bus_stop,
  output logic bus_abort
);
  initial begin
    cmd_byte = 8'h00;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    bus_stop = 1'b0;
    bus_abort = 1'b0;
  end

  task automatic set_cmd(input logic [7:0] cmd);
    @(posedge clock);
    #1;
    cmd_byte = cmd;
  endtask

  // A data byte is followed three cycles later by either stop or abort.
  task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data, input logic abort);
    set_cmd(cmd);
    wr_data = data;
    wr_strobe = 1'b1;
    @(posedge clock);
    #1;
    wr_strobe = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    bus_stop = ~abort;
    bus_abort = abort;
    @(posedge clock);
    #1;
    bus_stop = 1'b0;
    bus_abort = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int unsigned LOC = 20;
  // Identification values are arbitrary.
  localparam logic [7:0] MAKER = 8'h5A;
  localparam logic [7:0] PART = 8'h6B;
  localparam logic [7:0] REV = 8'h02;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic suspend_pin = 1'b0;
  logic sense = 1'b1;
  logic oc_event = 1'b0;
  logic period_end = 1'b0;
  logic [7:0] cmd_byte;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic bus_stop;
  logic bus_abort;
  logic [7:0] rd_data;
  logic lamp_enable;
  logic lamp_fault_flag;
  logic overcurrent_flag;
  logic [2:0] mode;
  int miscompares = 0;
  int compares = 0;

  always #5 clock = ~clock;

  smbus_host_model host (.clock(clock), .cmd_byte(cmd_byte), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .bus_stop(bus_stop), .bus_abort(bus_abort));

  lamp_shutdown_status_regs #(.LAMP_OUT_CYCLES(LOC), .MAKER_CODE(MAKER), .PART_CODE(PART),
    .REVISION_CODE(REV)) DUT (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .suspend_pin(suspend_pin), .lamp_current_sense(sense), .overcurrent_event(oc_event),
    .dimming_period_end(period_end), .bright_code(5'h15), .cmd_byte(cmd_byte),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .bus_stop(bus_stop), .bus_abort(bus_abort),
    .rd_data(rd_data), .lamp_enable(lamp_enable), .lamp_fault_flag(lamp_fault_flag),
    .overcurrent_flag(overcurrent_flag), .shutdown_mode_control(mode));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    host.set_cmd(cmd);
    cyc(2);
    chk(rd_data, exp);
  endtask

  // Pin synchroniser plus lamp and flag registers settle within five cycles.
  task automatic lamp(input logic en, input logic fault);
    cyc(5);
    chk({7'h00, lamp_enable}, {7'h00, en});
    chk({7'h00, lamp_fault_flag}, {7'h00, fault});
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_fault_clear();
    int i;
    for (i = 0; i < 100 && lamp_fault_flag !== 1'b0; i++) begin
      cyc(1);
    end
    if (i == 100) begin
      miscompares++;
      $display("mismatch at %0t: lamp fault flag never cleared", $time);
      final_report();
    end
  endtask

  task automatic period(input logic with_oc);
    oc_event = with_oc;
    cyc(1);
    oc_event = 1'b0;
    cyc(3);
    period_end = 1'b1;
    cyc(1);
    period_end = 1'b0;
    cyc(1);
  endtask

  initial begin
    cyc(8);
    sys_rst = 1'b0;
    rd(8'h02, 8'hF9);
    lamp(1'b0, 1'b1);
    suspend_pin = 1'b1;
    lamp(1'b1, 1'b1);
    host.write_byte(8'h02, 8'h04, 1'b1);
    lamp(1'b1, 1'b1);
    chk({5'h00, mode}, 8'h01);
    host.write_byte(8'h02, 8'h3A, 1'b0);
    rd(8'h02, 8'hFA);
    lamp(1'b0, 1'b1);
    suspend_pin = 1'b0;
    lamp(1'b1, 1'b1);
    host.write_byte(8'h02, 8'h04, 1'b0);
    lamp(1'b0, 1'b1);
    suspend_pin = 1'b1;
    lamp(1'b0, 1'b1);
    host.write_byte(8'h02, 8'h00, 1'b0);
    lamp(1'b1, 1'b1);
    sense = 1'b0;
    cyc(10);
    chk({7'h00, lamp_fault_flag}, 8'h01);
    wait_fault_clear();
    chk({7'h00, lamp_fault_flag}, 8'h00);
    sense = 1'b1;
    cyc(40);
    chk({7'h00, lamp_fault_flag}, 8'h00);
    chk({7'h00, lamp_enable}, 8'h00);
    rd(8'h02, 8'h78);
    host.write_byte(8'h03, 8'h55, 1'b0);
    host.write_byte(8'hFE, 8'h07, 1'b0);
    rd(8'h03, PART);
    rd(8'h00, REV);
    rd(8'hFE, MAKER);
    rd(8'hFF, PART);
    rd(8'h02, 8'h78);
    host.write_byte(8'h02, 8'h04, 1'b0);
    lamp(1'b0, 1'b1);
    host.write_byte(8'h02, 8'h00, 1'b0);
    lamp(1'b1, 1'b1);
    clk_en = 1'b0;
    host.write_byte(8'h02, 8'h04, 1'b0);
    clk_en = 1'b1;
    lamp(1'b1, 1'b1);
    chk({5'h00, mode}, 8'h00);
    period(1'b1);
    chk({7'h00, overcurrent_flag}, 8'h00);
    rd(8'hAA, 8'hAA);
    rd(8'hA9, 8'hA9);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    rd(8'h02, 8'hF9);
    rd(8'h01, 8'h15);
    period(1'b0);
    chk({7'h00, overcurrent_flag}, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
